// ### hw/tmz_timer.sv
// Purpose: 8-bit timer/counter with shared prescaler and option register
// Assumes: each enabled mclk cycle is one instruction cycle
// Notes: Avalon-MM slave, word address equals register index
// Notes on behaviour
// (R1) Count rolling from FFh to 00h sets the overflow flag.
// (R2) Overflow interrupt output only while its enable bit is set.
// (R3) Software clears the flag; hardware never clears it.
// (R4) Timer stops during sleep, so overflow never wakes.
// (R5) External count pin synchronised before counting; no prescaler passes straight.
// (R6) Source select 1 counts pin transitions, 0 counts instruction cycles.
// (R7) Edge select 1 counts falling pin edges, 0 rising.
// (R8) Assign bit 1 gives prescaler to watchdog, 0 to timer.
// (R9) Rate codes: timer 1:2 to 1:256, watchdog 1:1 to 1:128.
// (R10) Pull-up disable 1 kills all pull-ups, 0 uses individual enables.
// (R11) External interrupt on rising edge if 1, falling if 0.
// (R12) One 8-bit divide counter serves timer or watchdog, never both.
// (R13) Prescaler count has no software read or write path.
// (R14) Count writes clear prescaler while assigned to timer.
// (R15) Clear-watchdog clears prescaler and watchdog while assigned to watchdog.
// (R16) Software clears watchdog and count before moving prescaler to watchdog.
// (R17) Software clears watchdog before moving prescaler back to timer.
// (R18) Option resets to all ones; count untouched by reset.
// (R19) Internal mode without prescaler counts once per instruction cycle.
// (R20) After a count write, counting pauses two instruction cycles.
// (R21) With prescaler, count advances once per ratio of source events.
`timescale 1ns/1ps
`default_nettype none
module tmz_timer (
    input wire logic mclk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic sleep_mode,
    input wire logic external_count_pin,
    input wire logic ext_irq_pin,
    input wire logic clear_watchdog_instruction,
    input wire logic watchdog_base_tick,
    input wire logic [7:0] port_a_pullup_enables,
    output logic watchdog_timeout,
    output logic watchdog_clear,
    output logic timer_overflow_irq,
    output logic ext_irq_event,
    output logic [7:0] port_a_pullup_active,
    output logic [7:0] port_a_direction
);
    // ==========================================================
    // helpers
    function automatic logic edge_hit(input logic cur, input logic prev,
                                      input logic falling);
        edge_hit = falling ? (prev && !cur) : (cur && !prev);
    endfunction

    // ==========================================================
    // state
    logic [7:0] timer_count_q;
    logic [7:0] interrupt_control_q;
    logic [7:0] timer_option_control_q;
    logic [7:0] port_a_direction_q;
    logic [1:0] inhibit_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic [1:0] pin_s1_q;
    logic [1:0] pin_s2_q;
    logic [1:0] pin_s3_q;
    logic ext_irq_q;

    logic bus_req;
    logic wr_go;
    logic cnt_wr;
    logic ctl_wr;
    logic opt_wr;
    logic dir_wr;
    logic [7:0] wbyte;
    logic to_watchdog;
    logic [2:0] rate;
    logic pin_edge;
    logic src_evt;
    logic presc_evt;
    logic presc_clr;
    logic presc_tick;
    logic [7:0] presc_count;
    logic inc;
    logic overflow;

    // ==========================================================
    // bus slave: one wait cycle on every access
    assign bus_req = avs_read || avs_write;
    assign avs_waitrequest = bus_req && !ack_q;
    assign wr_go = clk_en && avs_write && ack_q;
    assign wbyte = avs_writedata[7:0];
    assign cnt_wr = wr_go && (avs_address == tmz_pkg::TIMER_COUNT_IDX);
    assign ctl_wr = wr_go && (avs_address == tmz_pkg::INTERRUPT_CONTROL_IDX);
    assign opt_wr = wr_go && (avs_address == tmz_pkg::TIMER_OPTION_CONTROL_IDX);
    assign dir_wr = wr_go && (avs_address == tmz_pkg::PORT_A_DIRECTION_IDX);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else if (clk_en) begin
            ack_q <= bus_req && !ack_q;
        end
    end

    // prescaler count is deliberately absent from the read map [R13]
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_q <= '0;
        end else if (clk_en && avs_read && !ack_q) begin
            case (avs_address)
                tmz_pkg::TIMER_COUNT_IDX: rdata_q <= {24'h00_0000, timer_count_q};
                tmz_pkg::INTERRUPT_CONTROL_IDX: rdata_q <= {24'h00_0000, interrupt_control_q};
                tmz_pkg::TIMER_OPTION_CONTROL_IDX: begin
                    rdata_q <= {24'h00_0000, timer_option_control_q};
                end
                tmz_pkg::PORT_A_DIRECTION_IDX: rdata_q <= {24'h00_0000, port_a_direction_q};
                default: rdata_q <= '0;
            endcase
        end
    end
    assign avs_readdata = rdata_q;

    // ==========================================================
    // option and direction registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            timer_option_control_q <= tmz_pkg::TIMER_OPTION_CONTROL_RST; // [R18]
        end else if (opt_wr) begin
            timer_option_control_q <= wbyte;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            port_a_direction_q <= tmz_pkg::PORT_A_DIRECTION_RST;
        end else if (dir_wr) begin
            port_a_direction_q <= wbyte & tmz_pkg::PORT_A_DIRECTION_MASK;
        end
    end
    assign port_a_direction = port_a_direction_q;

    assign to_watchdog = timer_option_control_q[tmz_pkg::PRESCALER_ASSIGN_BIT];
    assign rate = timer_option_control_q[tmz_pkg::PRESCALE_RATE_LSB +: tmz_pkg::PRESCALE_RATE_W];

    // ==========================================================
    // pin synchronisers: bit 0 count pin, bit 1 interrupt pin
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            pin_s3_q <= '0;
        end else if (clk_en) begin
            pin_s1_q <= {ext_irq_pin, external_count_pin}; // [R5]
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    assign pin_edge = edge_hit(pin_s2_q[0], pin_s3_q[0],
        timer_option_control_q[tmz_pkg::COUNT_EDGE_SELECT_BIT]); // [R7]

    // ==========================================================
    // external interrupt edge, registered
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ext_irq_q <= 1'b0;
        end else if (clk_en) begin
            ext_irq_q <= edge_hit(pin_s2_q[1], pin_s3_q[1],
                !timer_option_control_q[tmz_pkg::EXT_IRQ_EDGE_SELECT_BIT]); // [R11]
        end
    end
    assign ext_irq_event = ext_irq_q;

    // ==========================================================
    // pull-ups
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_pullup
            assign port_a_pullup_active[gi] = port_a_pullup_enables[gi]
                && !timer_option_control_q[tmz_pkg::PULLUP_DISABLE_BIT]; // [R10]
        end
    endgenerate

    // ==========================================================
    // source selection and prescaler routing
    // sleep gates the source, so the watchdog side keeps running
    always_comb begin
        if (sleep_mode) begin
            src_evt = 1'b0; // [R4]
        end else if (timer_option_control_q[tmz_pkg::COUNT_SOURCE_SELECT_BIT]) begin
            src_evt = pin_edge; // [R6]
        end else begin
            src_evt = 1'b1; // [R19]
        end
    end

    assign presc_evt = to_watchdog ? watchdog_base_tick : src_evt; // [R8]
    assign presc_clr = to_watchdog ? clear_watchdog_instruction : cnt_wr; // [R14] [R15]
    assign watchdog_clear = clear_watchdog_instruction; // [R15]
    // without the postscaler the watchdog times out on its base tick
    assign watchdog_timeout = clk_en && (to_watchdog ? presc_tick : watchdog_base_tick);

    tmz_presc u_presc (
        .mclk(mclk),
        .rst(rst),
        .clk_en(clk_en),
        .clr(presc_clr),
        .evt(presc_evt),
        .to_watchdog(to_watchdog),
        .rate(rate),
        .tick(presc_tick),
        .count(presc_count)
    );

    // ==========================================================
    // count register
    assign inc = clk_en && !cnt_wr && (inhibit_q == 2'h0)
        && (to_watchdog ? src_evt : presc_tick); // [R5] [R21]
    assign overflow = inc && (timer_count_q == tmz_pkg::COUNT_MAX);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            inhibit_q <= 2'h0;
        end else if (clk_en) begin
            if (cnt_wr) begin
                inhibit_q <= tmz_pkg::WRITE_INHIBIT_CYCLES; // [R20]
            end else if (inhibit_q != 2'h0) begin
                inhibit_q <= inhibit_q - 2'h1;
            end
        end
    end

    // no reset: the count keeps its value across every reset
    always_ff @(posedge mclk) begin
        if (cnt_wr) begin
            timer_count_q <= wbyte;
        end else if (inc) begin
            timer_count_q <= timer_count_q + 8'h01; // [R18] [R19]
        end
    end

    // ==========================================================
    // interrupt control: overflow set beats a software clear
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            interrupt_control_q <= tmz_pkg::INTERRUPT_CONTROL_RST;
        end else begin
            if (ctl_wr) begin
                interrupt_control_q <= wbyte; // [R3]
            end
            if (overflow) begin
                interrupt_control_q[tmz_pkg::TIMER_OVERFLOW_FLAG_BIT] <= 1'b1; // [R1]
            end
        end
    end

    assign timer_overflow_irq =
        interrupt_control_q[tmz_pkg::TIMER_OVERFLOW_FLAG_BIT]
        && interrupt_control_q[tmz_pkg::TIMER_OVERFLOW_IRQ_ENABLE_BIT]; // [R2]

    // ==========================================================
    // checks
    a_overflow_sets_flag: assert property (@(posedge mclk) disable iff (rst) // [R1]
        overflow |=> interrupt_control_q[tmz_pkg::TIMER_OVERFLOW_FLAG_BIT]
            && timer_count_q == 8'h00)
        else $error("overflow did not set flag");

    a_irq_masked: assert property (@(posedge mclk) disable iff (rst) // [R2]
        !interrupt_control_q[tmz_pkg::TIMER_OVERFLOW_IRQ_ENABLE_BIT] |-> !timer_overflow_irq)
        else $error("overflow interrupt not masked");

    a_flag_stays_set: assert property (@(posedge mclk) disable iff (rst) // [R3]
        interrupt_control_q[tmz_pkg::TIMER_OVERFLOW_FLAG_BIT] && !ctl_wr
            |=> interrupt_control_q[tmz_pkg::TIMER_OVERFLOW_FLAG_BIT])
        else $error("flag cleared by hardware");

    a_sleep_holds_count: assert property (@(posedge mclk) disable iff (rst) // [R4]
        sleep_mode && !cnt_wr |=> $stable(timer_count_q))
        else $error("count moved during sleep");

    a_internal_counts: assert property (@(posedge mclk) disable iff (rst) // [R19]
        clk_en && to_watchdog && !sleep_mode && !cnt_wr && inhibit_q == 2'h0
            && !timer_option_control_q[tmz_pkg::COUNT_SOURCE_SELECT_BIT]
            |=> timer_count_q == $past(timer_count_q) + 8'h01)
        else $error("internal count missed a cycle");

    a_write_inhibit: assert property (@(posedge mclk) disable iff (rst) // [R20]
        cnt_wr |=> !inc ##1 !inc)
        else $error("count advanced right after write");

    a_write_clears_presc: assert property (@(posedge mclk) disable iff (rst) // [R14]
        cnt_wr && !to_watchdog |=> presc_count == 8'h00)
        else $error("prescaler not cleared by count write");

    a_clear_watchdog_instruction_clears_presc: assert property (@(posedge mclk) disable iff (rst) // [R15]
        clk_en && clear_watchdog_instruction && to_watchdog |=> presc_count == 8'h00)
        else $error("prescaler not cleared by watchdog clear");

    a_wdt_one_to_one: assert property (@(posedge mclk) disable iff (rst) // [R9]
        clk_en && to_watchdog && rate == 3'h0 && watchdog_base_tick
            && !clear_watchdog_instruction |-> watchdog_timeout)
        else $error("watchdog 1:1 rate broken");

    a_bus_answers: assert property (@(posedge mclk) disable iff (rst)
        clk_en && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
endmodule
`default_nettype wire

// ### hw/tmz_pkg.sv
// Purpose: constants shared by the timer block and its divide counter
// Assumes: register offsets are register indices; byte address is four times index
// Notes: every field position, reset value and count lives here
package tmz_pkg;
    // ==========================================================
    // register indices
    localparam logic [7:0] TIMER_COUNT_IDX = 8'h01;
    localparam logic [7:0] INTERRUPT_CONTROL_IDX = 8'h0b;
    localparam logic [7:0] TIMER_OPTION_CONTROL_IDX = 8'h81;
    localparam logic [7:0] PORT_A_DIRECTION_IDX = 8'h85;
    // ==========================================================
    // reset values
    localparam logic [7:0] INTERRUPT_CONTROL_RST = 8'h00;
    localparam logic [7:0] TIMER_OPTION_CONTROL_RST = 8'hff;
    localparam logic [7:0] PORT_A_DIRECTION_RST = 8'h3f;
    localparam logic [7:0] PORT_A_DIRECTION_MASK = 8'h3f;
    // ==========================================================
    // interrupt control fields
    localparam int TIMER_OVERFLOW_FLAG_BIT = 2;
    localparam int TIMER_OVERFLOW_IRQ_ENABLE_BIT = 5;
    // ==========================================================
    // option fields
    localparam int PULLUP_DISABLE_BIT = 7;
    localparam int EXT_IRQ_EDGE_SELECT_BIT = 6;
    localparam int COUNT_SOURCE_SELECT_BIT = 5;
    localparam int COUNT_EDGE_SELECT_BIT = 4;
    localparam int PRESCALER_ASSIGN_BIT = 3;
    localparam int PRESCALE_RATE_LSB = 0;
    localparam int PRESCALE_RATE_W = 3;
    // ==========================================================
    // counts
    localparam logic [7:0] COUNT_MAX = 8'hff;
    localparam logic [1:0] WRITE_INHIBIT_CYCLES = 2'h2;
    localparam int PRESCALER_W = 8;
endpackage

// ### hw/tmz_presc.sv
// Purpose: shared 8-bit divide counter for the timer or the watchdog
// Assumes: evt is a one-cycle event on mclk; clr wins over counting
// Notes: the count is internal only and has no bus access
`timescale 1ns/1ps
`default_nettype none
module tmz_presc (
    input wire logic mclk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic clr,
    input wire logic evt,
    input wire logic to_watchdog,
    input wire logic [tmz_pkg::PRESCALE_RATE_W-1:0] rate,
    output logic tick,
    output logic [tmz_pkg::PRESCALER_W-1:0] count
);
    logic [tmz_pkg::PRESCALER_W-1:0] count_q;
    logic [tmz_pkg::PRESCALER_W-1:0] mask;
    logic [tmz_pkg::PRESCALER_W:0] span;

    // ==========================================================
    // ratio: timer 2 << rate, watchdog 1 << rate
    always_comb begin
        span = (tmz_pkg::PRESCALER_W+1)'(1) << rate;
        if (!to_watchdog) begin
            span = span << 1;
        end
        mask = tmz_pkg::PRESCALER_W'(span - 1'b1); // [R9]
    end

    // one tick per full ratio of events
    assign tick = evt && ((count_q & mask) == mask); // [R21]

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            count_q <= '0;
        end else if (clk_en) begin
            if (clr) begin
                count_q <= '0;
            end else if (evt) begin
                count_q <= count_q + 1'b1; // [R12]
            end
        end
    end

    assign count = count_q;
endmodule
`default_nettype wire

// ### verif/tmz_far.sv
// Purpose: far-side model: count pin source and watchdog base timer
// Assumes: tasks are called from the bench just after a rising edge
// Notes: counts watchdog timeout pulses for the bench to compare
`timescale 1ns/1ps
`default_nettype none
module tmz_far (
    input wire logic mclk,
    input wire logic watchdog_timeout,
    output logic external_count_pin,
    output logic watchdog_base_tick
);
    int timeouts = 0;

    initial begin
        external_count_pin = 1'b0;
        watchdog_base_tick = 1'b0;
    end

    always @(posedge mclk) begin
        if (watchdog_timeout === 1'b1) begin
            timeouts <= timeouts + 1;
        end
    end

    // ==========================================================
    // pin source
    // each level held two cycles so the synchroniser cannot miss it
    task automatic pin_pulses(input int n);
        repeat (n) begin
            repeat (2) @(posedge mclk);
            external_count_pin <= 1'b1;
            repeat (2) @(posedge mclk);
            external_count_pin <= 1'b0;
        end
    endtask

    // ==========================================================
    // watchdog base timer
    task automatic base_ticks(input int n);
        repeat (n) begin
            watchdog_base_tick <= 1'b1;
            @(posedge mclk);
            watchdog_base_tick <= 1'b0;
            @(posedge mclk);
        end
    endtask
endmodule
`default_nettype wire

// ### verif/tmz_timer_test.sv
// Purpose: self-checking bench for the timer block
// Assumes: bus access takes two cycles; read data compared by a monitor
// Notes: clk_en held high; sleep, pins and watchdog ticks all exercised
`timescale 1ns/1ps
`default_nettype none
module tmz_timer_test;
    localparam logic [7:0] CNT = tmz_pkg::TIMER_COUNT_IDX;
    localparam logic [7:0] ICR = tmz_pkg::INTERRUPT_CONTROL_IDX;
    localparam logic [7:0] OPT = tmz_pkg::TIMER_OPTION_CONTROL_IDX;
    localparam logic [7:0] DIR = tmz_pkg::PORT_A_DIRECTION_IDX;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic sleep_mode = 1'b0;
    logic ext_irq_pin = 1'b0;
    logic clear_watchdog_instruction = 1'b0;
    logic [7:0] port_a_pullup_enables = 8'h00;
    logic external_count_pin, watchdog_base_tick, watchdog_timeout;
    logic timer_overflow_irq, ext_irq_event;
    logic [7:0] port_a_pullup_active, port_a_direction;
    logic [7:0] expq[$];
    logic [7:0] d;
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;
    int ext_n = 0;
    int t0;

    always #5 mclk = ~mclk;

    tmz_timer dut_u (.mclk(mclk), .rst(rst), .clk_en(1'b1), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .sleep_mode(sleep_mode), .external_count_pin(external_count_pin),
        .ext_irq_pin(ext_irq_pin), .clear_watchdog_instruction(clear_watchdog_instruction),
        .watchdog_base_tick(watchdog_base_tick), .port_a_pullup_enables(port_a_pullup_enables),
        .watchdog_timeout(watchdog_timeout), .watchdog_clear(),
        .timer_overflow_irq(timer_overflow_irq), .ext_irq_event(ext_irq_event),
        .port_a_pullup_active(port_a_pullup_active), .port_a_direction(port_a_direction));

    tmz_far far_u (.mclk(mclk), .watchdog_timeout(watchdog_timeout),
        .external_count_pin(external_count_pin), .watchdog_base_tick(watchdog_base_tick));

    // ==========================================================
    // checking and closing
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        if (mismatches == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // read data is taken at the edge that sees waitrequest low
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (ext_irq_event === 1'b1) begin
            ext_n <= ext_n + 1;
        end
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            chk(avs_readdata, {24'h00_0000, expq.pop_front()});
        end
        if (cycles == 30000) begin
            mismatches++;
            end_sim();
        end
    end

    // ==========================================================
    // bus master
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] v);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= {24'h00_0000, v};
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n == 50) begin
            mismatches++;
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        // one idle edge so the next request never re-raises in this step
        @(posedge mclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        bus(1'b1, a, v);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        expq.push_back(e);
        bus(1'b0, a, 8'h00);
    endtask

    task automatic clear_wd();
        clear_watchdog_instruction <= 1'b1;
        @(posedge mclk);
        clear_watchdog_instruction <= 1'b0;
        @(posedge mclk);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        void'($urandom(30744));
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        port_a_pullup_enables <= 8'($urandom());
        @(posedge mclk);
        chk(32'(port_a_pullup_active), 32'h0000_0000);
        rd(OPT, 8'hff);
        rd(ICR, 8'h00);
        rd(DIR, 8'h3f);
        wr(8'h02, 8'h5a);
        rd(8'h02, 8'h00);
        d = 8'($urandom());
        wr(DIR, d);
        rd(DIR, d & 8'h3f);
        chk(32'(port_a_direction), 32'(d & 8'h3f));
        // internal source, prescaler away from the timer
        wr(OPT, 8'h08);
        d = 8'($urandom());
        wr(CNT, d);
        rd(CNT, d);
        rd(CNT, d + 8'h02);
        rd(CNT, d + 8'h05);
        rd(CNT, d + 8'h08);
        wr(ICR, 8'h20);
        wr(CNT, 8'hfd);
        repeat (4) @(posedge mclk);
        chk(32'(timer_overflow_irq), 32'h0000_0000);
        @(posedge mclk);
        chk(32'(timer_overflow_irq), 32'h0000_0001);
        rd(ICR, 8'h24);
        repeat (10) @(posedge mclk);
        rd(ICR, 8'h24);
        wr(ICR, 8'h04);
        @(posedge mclk);
        chk(32'(timer_overflow_irq), 32'h0000_0000);
        wr(ICR, 8'h00);
        rd(ICR, 8'h00);
        // every rate code on the pin, edge sense alternating
        clear_wd();
        for (int r = 0; r < 8; r++) begin
            wr(OPT, 8'h20 | (r[0] ? 8'h10 : 8'h00) | 8'(r));
            far_u.pin_pulses(1);
            wr(CNT, 8'h00);
            far_u.pin_pulses(3 * (2 << r));
            repeat (8) @(posedge mclk);
            rd(CNT, 8'h03);
        end
        t0 = far_u.timeouts;
        far_u.base_ticks(3);
        chk(32'(far_u.timeouts - t0), 32'h0000_0003);
        clear_wd();
        wr(CNT, 8'h00);
        wr(OPT, 8'h2f);
        clear_wd();
        wr(OPT, 8'h29);
        far_u.base_ticks(1);
        clear_wd();
        t0 = far_u.timeouts;
        far_u.base_ticks(5);
        chk(32'(far_u.timeouts - t0), 32'h0000_0002);
        for (int b = 0; b < 2; b++) begin
            wr(OPT, b[0] ? 8'h48 : 8'h08);
            t0 = ext_n;
            ext_irq_pin <= 1'b1;
            repeat (6) @(posedge mclk);
            ext_irq_pin <= 1'b0;
            repeat (6) @(posedge mclk);
            chk(32'(ext_n - t0), 32'h0000_0001);
        end
        chk(32'(port_a_pullup_active), 32'(port_a_pullup_enables));
        sleep_mode <= 1'b1;
        wr(CNT, 8'h55);
        repeat (20) @(posedge mclk);
        rd(CNT, 8'h55);
        wr(OPT, 8'h88);
        @(posedge mclk);
        chk(32'(port_a_pullup_active), 32'h0000_0000);
        // second reset: option back to ones, count kept
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd(OPT, 8'hff);
        rd(CNT, 8'h55);
        rd(ICR, 8'h00);
        end_sim();
    end
endmodule
`default_nettype wire
